/* File: core/bsc_cfg.svh */
// constants for the bus status and scl rate block
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_IDX_CTRL        8'hD8
`define BSC_IDX_STAT        8'hD9
`define BSC_IDX_SCLH        8'hDA
`define BSC_IDX_SCLL        8'hDB
`define BSC_ADDR_CTRL       12'h360
`define BSC_ADDR_STAT       12'h364
`define BSC_ADDR_SCLH       12'h368
`define BSC_ADDR_SCLL       12'h36C
`define BSC_BIT_RATESEL     0
`define BSC_BIT_ACK         2
`define BSC_BIT_SI          3
`define BSC_BIT_STOP        4
`define BSC_BIT_START       5
`define BSC_BIT_EN          6
`define BSC_CODE_LSB        3
`define BSC_CODE_NONE       8'hF8
`define BSC_CODE_FIELD_NONE 5'h1F
`define BSC_CODE_RESET      5'h00
`define BSC_COUNT_RESET     8'h00
`define BSC_GEN_TICK_DIV    2
`endif

/* File: core/bsc_pkg.sv */
// types for the bus status and scl rate block
package bsc_pkg;
	typedef struct packed {
		logic en;
		logic start;
		logic stop;
		logic si;
		logic ack;
		logic rate_source_select;
	} bsc_ctrl_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} bsc_event_t;

	typedef enum logic [1:0] {
		GEN_IDLE = 2'b00,
		GEN_HIGH = 2'b01,
		GEN_LOW  = 2'b10
	} bsc_gen_state_t;
endpackage

/* File: core/bsc_core.sv */
// status code register, control flags and scl rate generator
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"

module bsc_core
	import bsc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// protocol engine side
	input  wire bsc_event_t  bus_event,
	input  wire logic        stop_done,
	input  wire logic        irq_enable,
	input  wire logic        timer_ovf,
	output bsc_ctrl_t        ctrl_out,
	output logic             scl_gen,
	output logic             irq_req
);
	bsc_ctrl_t      ctrl_reg, ctrl_next;
	logic [4:0]     code_reg, code_next;
	logic [7:0]     sclh_reg, sclh_next;
	logic [7:0]     scll_reg, scll_next;
	logic           pready_reg, pready_next;
	logic [31:0]    prdata_reg, prdata_next;
	logic           pslverr_reg, pslverr_next;
	logic           irq_reg, irq_next;
	bsc_gen_state_t gen_reg, gen_next;
	logic [7:0]     cnt_reg, cnt_next;
	logic           div_reg, div_next;
	logic           scl_reg, scl_next;
	logic           access, wr_en, hit;
	logic [4:0]     ev_field;
	logic [8:0]     hi_run_reg, hi_run_next;
	logic [7:0]     hi_load_reg, hi_load_next;

	assign access   = psel & penable;
	assign ev_field = bus_event.code[7:`BSC_CODE_LSB];
	assign wr_en  = access & pready_reg & pwrite & pstrb[0];

	// apb answer, one wait state
	always_comb begin
		pready_next  = access & ~pready_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		hit          = 1'b1;
		case (paddr)
			`BSC_ADDR_CTRL: prdata_next = {24'h000000, 1'b0, ctrl_reg.en,
				ctrl_reg.start, ctrl_reg.stop, ctrl_reg.si, ctrl_reg.ack,
				1'b0, ctrl_reg.rate_source_select};
			`BSC_ADDR_STAT: prdata_next = {24'h000000, code_reg, 3'h0};
			`BSC_ADDR_SCLH: prdata_next = {24'h000000, sclh_reg};
			`BSC_ADDR_SCLL: prdata_next = {24'h000000, scll_reg};
			default: begin
				prdata_next = 32'h00000000;
				hit         = 1'b0;
			end
		endcase
		if (!(access & ~pready_reg)) begin
			prdata_next = prdata_reg;
		end else begin
			pslverr_next = ~hit;
		end
	end

	// control, count and status registers
	always_comb begin
		ctrl_next = ctrl_reg;
		sclh_next = sclh_reg;
		scll_next = scll_reg;
		code_next = code_reg;
		if (wr_en && paddr == `BSC_ADDR_CTRL) begin
			ctrl_next.en                 = pwdata[`BSC_BIT_EN];
			ctrl_next.start              = pwdata[`BSC_BIT_START];
			ctrl_next.stop               = pwdata[`BSC_BIT_STOP];
			ctrl_next.ack                = pwdata[`BSC_BIT_ACK];
			ctrl_next.rate_source_select = pwdata[`BSC_BIT_RATESEL];
			if (!pwdata[`BSC_BIT_SI]) begin
				ctrl_next.si = 1'b0;
			end
		end
		if (wr_en && paddr == `BSC_ADDR_SCLH) begin
			sclh_next = pwdata[7:0];
		end
		if (wr_en && paddr == `BSC_ADDR_SCLL) begin
			scll_next = pwdata[7:0];
		end
		if (stop_done) begin
			ctrl_next.stop = 1'b0;
		end
		// status code has no write path
		if (!ctrl_reg.en) begin
			code_next = `BSC_CODE_RESET;
			if (ctrl_next.en) begin
				code_next = `BSC_CODE_FIELD_NONE;
			end
		end else if (bus_event.valid) begin
			code_next = ev_field;
			if (ev_field != `BSC_CODE_FIELD_NONE) begin
				ctrl_next.si = 1'b1;
			end
		end
		irq_next = ctrl_next.si & irq_enable;
	end

	// scl generator
	always_comb begin
		div_next = ~div_reg;
		gen_next = gen_reg;
		cnt_next = cnt_reg;
		scl_next = scl_reg;
		if (!ctrl_reg.en) begin
			gen_next = GEN_IDLE;
			scl_next = 1'b1;
			div_next = 1'b0;
		end else if (ctrl_reg.rate_source_select) begin
			gen_next = GEN_IDLE;
			if (timer_ovf) begin
				scl_next = ~scl_reg;
			end
		end else begin
			case (gen_reg)
				GEN_IDLE: begin
					gen_next = GEN_HIGH;
					cnt_next = sclh_reg;
					scl_next = 1'b1;
					div_next = 1'b0;
				end
				GEN_HIGH: begin
					if (div_reg) begin
						if (cnt_reg <= 8'h01) begin
							gen_next = GEN_LOW;
							cnt_next = scll_reg;
							scl_next = 1'b0;
						end else begin
							cnt_next = cnt_reg - 8'h01;
						end
					end
				end
				GEN_LOW: begin
					if (div_reg) begin
						if (cnt_reg <= 8'h01) begin
							gen_next = GEN_HIGH;
							cnt_next = sclh_reg;
							scl_next = 1'b1;
						end else begin
							cnt_next = cnt_reg - 8'h01;
						end
					end
				end
				default: begin
					gen_next = GEN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg    <= '0;
			code_reg    <= `BSC_CODE_RESET;
			sclh_reg    <= `BSC_COUNT_RESET;
			scll_reg    <= `BSC_COUNT_RESET;
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
			irq_reg     <= 1'b0;
			gen_reg     <= GEN_IDLE;
			cnt_reg     <= `BSC_COUNT_RESET;
			div_reg     <= 1'b0;
			scl_reg     <= 1'b1;
		end else begin
			ctrl_reg    <= ctrl_next;
			code_reg    <= code_next;
			sclh_reg    <= sclh_next;
			scll_reg    <= scll_next;
			pready_reg  <= pready_next;
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
			irq_reg     <= irq_next;
			gen_reg     <= gen_next;
			cnt_reg     <= cnt_next;
			div_reg     <= div_next;
			scl_reg     <= scl_next;
		end
	end

	assign pready   = pready_reg;
	assign prdata   = prdata_reg;
	assign pslverr  = pslverr_reg;
	assign ctrl_out = ctrl_reg;
	assign scl_gen  = scl_reg;
	assign irq_req  = irq_reg;

	// high phase length, for the checks
	always_comb begin
		hi_run_next  = 9'h000;
		hi_load_next = hi_load_reg;
		if (gen_reg == GEN_HIGH) begin
			hi_run_next = hi_run_reg + 9'h001;
		end
		if (gen_next == GEN_HIGH && gen_reg != GEN_HIGH) begin
			hi_load_next = sclh_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_run_reg  <= 9'h000;
			hi_load_reg <= `BSC_COUNT_RESET;
		end else begin
			hi_run_reg  <= hi_run_next;
			hi_load_reg <= hi_load_next;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_stat_write_blocked: assert property (
		(wr_en && paddr == `BSC_ADDR_STAT && !bus_event.valid && ctrl_reg.en
			&& code_reg != `BSC_CODE_RESET) |=> $stable(code_reg))
		else $error("status code changed by a write");
	a_stat_low_zero: assert property (
		(pready && paddr == `BSC_ADDR_STAT) |-> prdata[2:0] == 3'h0)
		else $error("status low bits not zero");
	a_none_no_flag: assert property (
		(ctrl_reg.en && bus_event.valid && ev_field == `BSC_CODE_FIELD_NONE
			&& !ctrl_reg.si && !wr_en) |=> !ctrl_reg.si)
		else $error("flag set on code F8");
	a_event_loads: assert property (
		(ctrl_reg.en && bus_event.valid && ev_field != `BSC_CODE_FIELD_NONE)
			|=> ctrl_reg.si && code_reg == $past(ev_field))
		else $error("state entry not recorded");
	a_flag_irq: assert property (
		irq_req == (ctrl_reg.si && $past(irq_enable)))
		else $error("irq not following the flag");
	a_flag_sticky: assert property (
		(ctrl_reg.si && !wr_en) |=> ctrl_reg.si)
		else $error("flag dropped without a write");
	a_high_phase: assert property (
		($fell(scl_reg) && gen_reg == GEN_LOW) |-> hi_run_reg ==
			((hi_load_reg == 8'h00) ? 9'h002 : {hi_load_reg, 1'b0}))
		else $error("scl high time wrong");
	a_timer_toggle: assert property (
		(ctrl_reg.en && ctrl_reg.rate_source_select && timer_ovf
			&& $stable(ctrl_reg)) |=> scl_reg != $past(scl_reg))
		else $error("scl not toggled on timer");
	a_reset_code: assert property (
		!ctrl_reg.en |=> code_reg == (ctrl_reg.en ? `BSC_CODE_FIELD_NONE
			: `BSC_CODE_RESET))
		else $error("code not zero while disabled");

	c_event_seen: cover property (ctrl_reg.en && bus_event.valid);
	c_flag_clear: cover property ($fell(ctrl_reg.si));
	c_scl_low: cover property ($fell(scl_reg) && !ctrl_reg.rate_source_select);
	c_bad_addr: cover property (pslverr);
endmodule
`default_nettype wire

/* File: dv/bsc_engine_model.sv */
// protocol engine stand-in: state entries and timer ticks
`timescale 1ns/1ps
`default_nettype none
module bsc_engine_model
	import bsc_pkg::*;
(
	// clock
	input  wire logic     pclk,
	// engine outputs
	output var bsc_event_t bus_event,
	output logic          stop_done,
	output logic          timer_ovf
);
	initial begin
		bus_event = '0;
		stop_done = 1'b0;
		timer_ovf = 1'b0;
	end
	// one-cycle state entry, code inverted once released
	task automatic post(input logic [7:0] code);
		@(posedge pclk);
		bus_event <= '{valid: 1'b1, code: code};
		@(posedge pclk);
		bus_event <= '{valid: 1'b0, code: ~code};
	endtask
	// one-cycle timer overflow
	task automatic tick();
		@(posedge pclk);
		timer_ovf <= 1'b1;
		@(posedge pclk);
		timer_ovf <= 1'b0;
	endtask
	// one-cycle stop finished on the line
	task automatic halt();
		@(posedge pclk);
		stop_done <= 1'b1;
		@(posedge pclk);
		stop_done <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the status and scl rate block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"
module tb
	import bsc_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic        irq_enable, stop_done, timer_ovf, scl_gen, irq_req, s;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [32:0] x;
	logic [4:0]  c;
	logic [7:0]  h;
	bsc_event_t  bus_event;
	bsc_ctrl_t   ctrl_out;
	logic [32:0] exp_q[$];
	int          miscompares = 0;
	int          num_checks = 0;
	int          n, hs, ls;

	always #5 pclk = ~pclk;

	bsc_core i_bsc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .bus_event(bus_event),
		.stop_done(stop_done), .irq_enable(irq_enable),
		.timer_ovf(timer_ovf), .ctrl_out(ctrl_out),
		.scl_gen(scl_gen), .irq_req(irq_req));
	bsc_engine_model i_bsc_engine_model (.pclk(pclk),
		.bus_event(bus_event), .stop_done(stop_done),
		.timer_ovf(timer_ovf));

	task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
		num_checks++;
		if (v !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
		logic [32:0] e = '0);
		exp_q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic span(logic lv, output int k);
		k = 0;
		while (scl_gen === lv) begin
			@(negedge pclk);
			k++;
		end
	endtask

	// answer monitor against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			x = exp_q.pop_front();
			chk("pslverr", {31'h0, x[32]}, {31'h0, pslverr});
			if (!pwrite)
				chk("prdata", x[31:0], prdata);
		end
	end

	initial begin
		#200us;
		miscompares++;
		complete_run();
	end

	initial begin
		{psel, penable, pwrite, irq_enable, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		s = 1'($urandom(53));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `BSC_ADDR_STAT, 0, 33'h0);
		apb(0, `BSC_ADDR_CTRL, 0, 33'h0);
		apb(0, 12'h370, 0, {1'b1, 32'h0});
		$display("test reset done");
		apb(1, `BSC_ADDR_CTRL, 32'h40);
		apb(0, `BSC_ADDR_STAT, 0, 33'hF8);
		c = 5'($urandom_range(30, 0));
		irq_enable <= 1'b1;
		i_bsc_engine_model.post({c, 3'b101});
		apb(0, `BSC_ADDR_STAT, 0, {c, 3'b000});
		apb(0, `BSC_ADDR_CTRL, 0, 33'h48);
		@(negedge pclk);
		chk("irq_req", 1, {31'h0, irq_req});
		apb(1, `BSC_ADDR_STAT, 32'h0);
		apb(0, `BSC_ADDR_STAT, 0, {c, 3'b000});
		apb(1, `BSC_ADDR_CTRL, 32'h40);
		apb(0, `BSC_ADDR_CTRL, 0, 33'h40);
		apb(1, `BSC_ADDR_CTRL, 32'h50);
		@(negedge pclk);
		chk("ctrl_out", 32'h28, {26'h0, ctrl_out});
		i_bsc_engine_model.halt();
		apb(0, `BSC_ADDR_CTRL, 0, 33'h40);
		i_bsc_engine_model.post(8'hF8);
		apb(0, `BSC_ADDR_STAT, 0, 33'hF8);
		apb(0, `BSC_ADDR_CTRL, 0, 33'h40);
		$display("test status done");
		h = 8'($urandom_range(70, 62));
		apb(1, `BSC_ADDR_SCLH, {24'h0, h});
		apb(1, `BSC_ADDR_SCLL, {24'h0, h + 8'h01});
		apb(0, `BSC_ADDR_SCLH, 0, {25'h0, h});
		@(negedge pclk);
		span(1, n);
		span(0, n);
		span(1, hs);
		span(0, ls);
		chk("scl high", 32'(h) * 2, 32'(hs));
		chk("scl low", 32'(h) * 2 + 2, 32'(ls));
		$display("test generator done");
		apb(1, `BSC_ADDR_CTRL, 32'h41);
		repeat (2) @(negedge pclk);
		s = scl_gen;
		repeat (8) @(negedge pclk);
		chk("scl hold", {31'h0, s}, {31'h0, scl_gen});
		i_bsc_engine_model.tick();
		repeat (2) @(negedge pclk);
		chk("scl tick", {31'h0, ~s}, {31'h0, scl_gen});
		$display("test timer done");
		complete_run();
	end
endmodule
`default_nettype wire
